// ==== rtl/pei_hold_timer.sv ====
`timescale 1ns/10ps
// asserts done once cond has held for LIMIT consecutive clocks
module pei_hold_timer #(
  parameter int LIMIT = 2
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic cond,
  output logic      done
);

  localparam int CW = $clog2(LIMIT + 1);
  localparam logic [CW-1:0] CNT_MAX = CW'(LIMIT);

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;

  always_comb begin
    if (!cond) begin
      cnt_nxt = '0;
    end else if (cnt_r == CNT_MAX) begin
      cnt_nxt = cnt_r;
    end else begin
      cnt_nxt = cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign done = cond && (cnt_r == CNT_MAX);

endmodule

// ==== rtl/pei_pkg.sv ====
package pei_pkg;

  // special function register addresses
  localparam logic [7:0] ADDR_ENABLE = 8'hEC;
  localparam logic [7:0] ADDR_PERIPHERAL_CONFIGURATION = 8'hF4;
  localparam logic [7:0] ADDR_SWCFG  = 8'hF5;
  localparam logic [7:0] ADDR_FLAGS  = 8'hF8;
  localparam logic [7:0] ADDR_IEP2   = 8'hA9;

  // bit positions: events shared by enable and flag registers, then status and control bits
  localparam int BIT_DCIN    = 0;
  localparam int BIT_SWITCH  = 1;
  localparam int BIT_DIP     = 5;
  localparam int BIT_PENDING = 6;
  localparam int BIT_RESTORE = 7;
  localparam int BIT_SOURCE  = 6;
  localparam int BIT_GLOBAL  = 1;
  localparam int BIT_PRG_OFF = 1;

  localparam logic [7:0] EVENT_MASK     = 8'hA3;
  localparam logic [7:0] SWCFG_MASK     = 8'h03;
  localparam logic [1:0] PRG_VDD_ONLY   = 2'h0;
  localparam logic [1:0] PRG_VDD_DCIN   = 2'h1;
  localparam logic [7:0] RST_ENABLE     = 8'h00;
  localparam logic [7:0] RST_FLAGS      = 8'h00;
  localparam logic [7:0] RST_PERIPHERAL_CONFIGURATION     = 8'h00;
  localparam logic [1:0] RST_SWCFG      = 2'h0;
  localparam logic [7:0] RST_IEP2       = 8'h00;
  localparam logic [7:0] RDATA_NONE     = 8'h00;

  // timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int T_MIN_NS      = 10;
  localparam int T_DCIN_MS     = 30;
  localparam int T_RESTORE_MS  = 130;
  localparam int MIN_CYC =
    (T_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int DCIN_CYC =
    (T_DCIN_MS * 1000000 / CLK_PERIOD_PS) * 1000;
  localparam int RESTORE_CYC =
    (T_RESTORE_MS * 1000000 / CLK_PERIOD_PS) * 1000;

  typedef enum logic {
    PEI_MAIN = 1'b0,
    PEI_BATT = 1'b1
  } pei_src_t;

endpackage

// ==== rtl/pei_top.sv ====
`timescale 1ns/10ps
module pei_top #(
  parameter int DCIN_CYC    = pei_pkg::DCIN_CYC,
  parameter int RESTORE_CYC = pei_pkg::RESTORE_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata_r,
  input  wire logic       main_low_in,
  input  wire logic       dc_low_in,
  input  wire logic       line_dip_in,
  output logic            on_battery_r,
  output logic            psm_irq_r
);

  // level inputs from the analog side, two flops each
  localparam int NSYNC = 3;
  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] meta_r;
  logic [NSYNC-1:0] sync_r;
  logic             main_low_s;
  logic             dc_low_s;
  logic             line_dip_s;

  assign async_in = {line_dip_in, dc_low_in, main_low_in};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_r[gi] <= 1'b0;
          sync_r[gi] <= 1'b0;
        end else begin
          meta_r[gi] <= async_in[gi];
          sync_r[gi] <= meta_r[gi];
        end
      end
    end
  endgenerate

  assign main_low_s = sync_r[0];
  assign dc_low_s   = sync_r[1];
  assign line_dip_s = sync_r[2];

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  // register state
  logic [7:0]       enable_r;
  logic [7:0]       enable_nxt;
  logic [7:0]       flags_r;
  logic [7:0]       flags_nxt;
  logic [7:0]       peripheral_configuration_r;
  logic [7:0]       peripheral_configuration_nxt;
  logic [1:0]       swcfg_r;
  logic [1:0]       swcfg_nxt;
  logic [7:0]       iep2_r;
  logic [7:0]       iep2_nxt;
  logic [7:0]       rdata_nxt;
  logic             irq_nxt;
  pei_pkg::pei_src_t src_r;
  pei_pkg::pei_src_t src_nxt;
  logic             to_batt;
  logic             to_main;
  logic [7:0]       set_vec;
  logic [7:0]       clr_vec;
  logic [7:0]       pend_vec;
  logic             sw_off;
  logic             dcin_cause;

  // comparator persistence timers
  logic main_trip;
  logic dc_trip;
  logic dc_flag_ok;
  logic restore_ok;
  logic restore_cond;

  assign sw_off     = swcfg_r[pei_pkg::BIT_PRG_OFF];
  assign dcin_cause = (swcfg_r == pei_pkg::PRG_VDD_DCIN);

  pei_hold_timer #(.LIMIT(pei_pkg::MIN_CYC)) u_main_tmr (
    .clk   (clk),
    .rst_n (rst_n),
    .cond  (main_low_s && (src_r == pei_pkg::PEI_MAIN)),
    .done  (main_trip)
  );

  pei_hold_timer #(.LIMIT(DCIN_CYC)) u_dcsw_tmr (
    .clk   (clk),
    .rst_n (rst_n),
    .cond  (dc_low_s && dcin_cause && (src_r == pei_pkg::PEI_MAIN)),
    .done  (dc_trip)
  );

  pei_hold_timer #(.LIMIT(pei_pkg::MIN_CYC)) u_dcfl_tmr (
    .clk   (clk),
    .rst_n (rst_n),
    .cond  (dc_low_s),
    .done  (dc_flag_ok)
  );

  // restore needs main good, and dc good too when dc may switch
  assign restore_cond = (src_r == pei_pkg::PEI_BATT) && !main_low_s &&
                        !(dcin_cause && dc_low_s);

  pei_hold_timer #(.LIMIT(RESTORE_CYC)) u_rest_tmr (
    .clk   (clk),
    .rst_n (rst_n),
    .cond  (restore_cond),
    .done  (restore_ok)
  );

  // supply source state
  always_comb begin
    src_nxt = src_r;
    unique case (src_r)
      pei_pkg::PEI_MAIN: begin
        if (!sw_off && (main_trip || (dcin_cause && dc_trip))) begin
          src_nxt = pei_pkg::PEI_BATT;
        end
      end
      pei_pkg::PEI_BATT: begin
        if (sw_off || restore_ok) begin
          src_nxt = pei_pkg::PEI_MAIN;
        end
      end
    endcase
  end

  assign to_batt = (src_r == pei_pkg::PEI_MAIN) &&
                   (src_nxt == pei_pkg::PEI_BATT);
  assign to_main = (src_r == pei_pkg::PEI_BATT) &&
                   (src_nxt == pei_pkg::PEI_MAIN);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      src_r        <= pei_pkg::PEI_MAIN;
      on_battery_r <= 1'b0;
    end else begin
      src_r        <= src_nxt;
      on_battery_r <= (src_nxt == pei_pkg::PEI_BATT);
    end
  end

  // flag set and clear vectors
  always_comb begin
    set_vec = 8'h00;
    set_vec[pei_pkg::BIT_SWITCH]  = to_batt;
    set_vec[pei_pkg::BIT_RESTORE] = to_main;
    set_vec[pei_pkg::BIT_DCIN]    = dc_flag_ok;
    set_vec[pei_pkg::BIT_DIP]     = line_dip_s;
    clr_vec = 8'h00;
    if (sfr_wr && hit(sfr_addr, pei_pkg::ADDR_FLAGS)) begin
      clr_vec = ~sfr_wdata & pei_pkg::EVENT_MASK;
    end
  end

  // register writes
  always_comb begin
    enable_nxt = enable_r;
    peripheral_configuration_nxt = peripheral_configuration_r;
    swcfg_nxt  = swcfg_r;
    iep2_nxt   = iep2_r;
    flags_nxt  = ((flags_r & ~clr_vec) | set_vec) &
                 pei_pkg::EVENT_MASK;
    if (sfr_wr) begin
      if (hit(sfr_addr, pei_pkg::ADDR_ENABLE)) begin
        enable_nxt = sfr_wdata & pei_pkg::EVENT_MASK;
      end
      if (hit(sfr_addr, pei_pkg::ADDR_PERIPHERAL_CONFIGURATION)) begin
        peripheral_configuration_nxt = sfr_wdata;
      end
      if (hit(sfr_addr, pei_pkg::ADDR_SWCFG)) begin
        swcfg_nxt = sfr_wdata[1:0];
      end
      if (hit(sfr_addr, pei_pkg::ADDR_IEP2)) begin
        iep2_nxt = sfr_wdata;
      end
    end
  end

  assign pend_vec = flags_r & enable_r;

  always_comb begin
    irq_nxt = iep2_r[pei_pkg::BIT_GLOBAL] && (|pend_vec);
  end

  // read path, one cycle latency
  always_comb begin
    rdata_nxt = sfr_rdata_r;
    if (sfr_rd) begin
      rdata_nxt = pei_pkg::RDATA_NONE;
      if (hit(sfr_addr, pei_pkg::ADDR_ENABLE)) begin
        rdata_nxt = enable_r;
      end
      if (hit(sfr_addr, pei_pkg::ADDR_FLAGS)) begin
        rdata_nxt = flags_r;
        rdata_nxt[pei_pkg::BIT_PENDING] = |pend_vec;
      end
      if (hit(sfr_addr, pei_pkg::ADDR_PERIPHERAL_CONFIGURATION)) begin
        rdata_nxt = peripheral_configuration_r;
        rdata_nxt[pei_pkg::BIT_SOURCE] =
          (src_r == pei_pkg::PEI_MAIN);
      end
      if (hit(sfr_addr, pei_pkg::ADDR_SWCFG)) begin
        rdata_nxt = {6'h00, swcfg_r};
      end
      if (hit(sfr_addr, pei_pkg::ADDR_IEP2)) begin
        rdata_nxt = iep2_r;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_r    <= pei_pkg::RST_ENABLE;
      flags_r     <= pei_pkg::RST_FLAGS;
      peripheral_configuration_r    <= pei_pkg::RST_PERIPHERAL_CONFIGURATION;
      swcfg_r     <= pei_pkg::RST_SWCFG;
      iep2_r      <= pei_pkg::RST_IEP2;
      sfr_rdata_r <= pei_pkg::RDATA_NONE;
      psm_irq_r   <= 1'b0;
    end else begin
      enable_r    <= enable_nxt;
      flags_r     <= flags_nxt;
      peripheral_configuration_r    <= peripheral_configuration_nxt;
      swcfg_r     <= swcfg_nxt;
      iep2_r      <= iep2_nxt;
      sfr_rdata_r <= rdata_nxt;
      psm_irq_r   <= irq_nxt;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  switch_flag_a: assert property (
    $rose(on_battery_r) |-> flags_r[pei_pkg::BIT_SWITCH]
  ) else $error("switchover flag not set on battery switch");

  restore_flag_a: assert property (
    $fell(on_battery_r) |-> flags_r[pei_pkg::BIT_RESTORE]
  ) else $error("restore flag not set on return to main");

  flag_latch_a: assert property (
    (flags_r[pei_pkg::BIT_SWITCH] && !clr_vec[pei_pkg::BIT_SWITCH])
    |=> flags_r[pei_pkg::BIT_SWITCH]
  ) else $error("switchover flag dropped without clear");

  flag_clear_a: assert property (
    (clr_vec[pei_pkg::BIT_RESTORE] && !to_main)
    |=> !flags_r[pei_pkg::BIT_RESTORE]
  ) else $error("restore flag not cleared by zero write");

  set_wins_a: assert property (
    (|(set_vec & clr_vec))
    |=> ((flags_r & $past(set_vec)) == $past(set_vec))
  ) else $error("clear beat a same-cycle flag event");

  source_bit_a: assert property (
    (sfr_rd && hit(sfr_addr, pei_pkg::ADDR_PERIPHERAL_CONFIGURATION))
    |=> sfr_rdata_r[pei_pkg::BIT_SOURCE] == !$past(on_battery_r)
  ) else $error("source status bit wrong");

  dcin_delay_a: assert property (
    $rose(dc_low_s) && !flags_r[pei_pkg::BIT_DCIN]
    |-> !flags_r[pei_pkg::BIT_DCIN] [*2]
  ) else $error("dc low flag raised too early");

  dcin_flag_a: assert property (
    dc_low_s [*3] |=> flags_r[pei_pkg::BIT_DCIN]
  ) else $error("dc low flag not raised");

  main_switch_a: assert property (
    (!on_battery_r && !sw_off && main_low_s && !to_batt && !main_trip)
    ##1 (main_low_s && !sw_off) [*2] |=> on_battery_r
  ) else $error("no switch on main supply low");

  off_a: assert property (
    sw_off |=> !on_battery_r
  ) else $error("battery rail while switchover disabled");

  irq_gate_a: assert property (
    !iep2_r[pei_pkg::BIT_GLOBAL] |=> !psm_irq_r
  ) else $error("irq without global enable");

  irq_or_a: assert property (
    ##1 psm_irq_r == ($past(iep2_r[pei_pkg::BIT_GLOBAL]) &&
                      |($past(flags_r) & $past(enable_r)))
  ) else $error("irq not flag and enable OR");

  dip_flag_a: assert property (
    line_dip_s |=> flags_r[pei_pkg::BIT_DIP]
  ) else $error("line dip flag not set");

  cover_switch_c:  cover property ($rose(on_battery_r));
  cover_restore_c: cover property ($fell(on_battery_r));
  cover_irq_c:     cover property ($rose(psm_irq_r));
  cover_race_c:    cover property (to_batt && clr_vec[pei_pkg::BIT_SWITCH]);

endmodule

// ==== verif/pei_afe_model.sv ====
`timescale 1ns/10ps
// comparators and sag qualifier that feed the block; they move
// just after a clock edge
module pei_afe_model (
  input  wire logic clk,
  input  wire logic vdd_ok,
  input  wire logic dcin_ok,
  input  wire logic sag_seen,
  output logic      main_low,
  output logic      dc_low,
  output logic      dip
);
  always_ff @(posedge clk) begin
    main_low <= !vdd_ok;
    dc_low   <= !dcin_ok;
    dip      <= sag_seen;
  end
endmodule

// ==== verif/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
  logic       clk;
  logic       rst_n;
  logic [7:0] sfr_addr;
  logic       sfr_wr;
  logic       sfr_rd;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata_r;
  logic       main_low_in;
  logic       dc_low_in;
  logic       line_dip_in;
  logic       on_battery_r;
  logic       psm_irq_r;
  logic       vdd_ok;
  logic       dcin_ok;
  logic       sag_seen;
  int         fails;
  int         n_tests;
  logic [7:0] rst_addr [6] = '{8'hEC, 8'hF4, 8'hF5, 8'hF8, 8'hA9, 8'h10};
  logic [7:0] rst_exp  [6] = '{8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00};

  pei_top #(.DCIN_CYC(20), .RESTORE_CYC(40)) pei_top_i (
    .clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata_r(sfr_rdata_r),
    .main_low_in(main_low_in), .dc_low_in(dc_low_in),
    .line_dip_in(line_dip_in), .on_battery_r(on_battery_r),
    .psm_irq_r(psm_irq_r)
  );

  pei_afe_model pei_afe_model_i (
    .clk(clk), .vdd_ok(vdd_ok), .dcin_ok(dcin_ok), .sag_seen(sag_seen),
    .main_low(main_low_in), .dc_low(dc_low_in), .dip(line_dip_in)
  );

  task automatic summarize();
    if (fails == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // waits n edges, then lets that edge's updates settle
  task automatic obs(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    #1;
    chk(sfr_rdata_r, exp);
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    #10000;
    fails++;
    summarize();
  end

  initial begin
    rst_n     = 1'b0;
    sfr_addr  = 8'h00;
    sfr_wr    = 1'b0;
    sfr_rd    = 1'b0;
    sfr_wdata = 8'h00;
    vdd_ok    = 1'b1;
    dcin_ok   = 1'b1;
    sag_seen  = 1'b0;
    fails     = 0;
    n_tests   = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(rst_addr[i], rst_exp[i]);
    end
    wr(8'hEC, 8'hFF);
    rd(8'hEC, 8'hA3);
    wr(8'hF5, 8'hFF);
    rd(8'hF5, 8'h03);
    wr(8'hF5, 8'h00);
    wr(8'hF4, 8'hBF);
    rd(8'hF4, 8'hFF);
    wr(8'hF4, 8'h00);
    wr(8'hA9, 8'h02);
    // main supply fails
    @(posedge clk) vdd_ok <= 1'b0;
    obs(2);
    chk(on_battery_r, 1'b0);
    obs(6);
    chk(on_battery_r, 1'b1);
    rd(8'hF4, 8'h00);
    rd(8'hF8, 8'h42);
    chk(psm_irq_r, 1'b1);
    wr(8'hF8, 8'hFF);
    rd(8'hF8, 8'h42);
    wr(8'hF8, 8'h00);
    rd(8'hF8, 8'h00);
    obs(1);
    chk(psm_irq_r, 1'b0);
    // main supply returns
    @(posedge clk) vdd_ok <= 1'b1;
    obs(30);
    chk(on_battery_r, 1'b1);
    obs(20);
    chk(on_battery_r, 1'b0);
    rd(8'hF8, 8'hC0);
    chk(psm_irq_r, 1'b1);
    wr(8'hF8, 8'h00);
    // same events with every event enable cleared, global enable still set
    wr(8'hEC, 8'h00);
    @(posedge clk) vdd_ok <= 1'b0;
    obs(10);
    rd(8'hF8, 8'h02);
    chk(psm_irq_r, 1'b0);
    @(posedge clk) vdd_ok <= 1'b1;
    obs(50);
    rd(8'hF8, 8'h82);
    chk(psm_irq_r, 1'b0);
    wr(8'hF8, 8'h00);
    // dc input low, switching on main only
    wr(8'hEC, 8'h01);
    @(posedge clk) dcin_ok <= 1'b0;
    @(posedge clk) dcin_ok <= 1'b1;
    obs(10);
    rd(8'hF8, 8'h00);
    @(posedge clk) dcin_ok <= 1'b0;
    obs(30);
    rd(8'hF8, 8'h41);
    chk(psm_irq_r, 1'b1);
    chk(on_battery_r, 1'b0);
    wr(8'hF8, 8'h00);
    rd(8'hF8, 8'h41);
    wr(8'hA9, 8'h00);
    obs(3);
    chk(psm_irq_r, 1'b0);
    wr(8'hA9, 8'h02);
    @(posedge clk) dcin_ok <= 1'b1;
    obs(5);
    wr(8'hF8, 8'h00);
    // dc input low may switch the rail too
    wr(8'hF5, 8'h01);
    @(posedge clk) dcin_ok <= 1'b0;
    obs(12);
    chk(on_battery_r, 1'b0);
    obs(18);
    chk(on_battery_r, 1'b1);
    obs(50);
    chk(on_battery_r, 1'b1);
    @(posedge clk) dcin_ok <= 1'b1;
    obs(50);
    chk(on_battery_r, 1'b0);
    // line dip
    wr(8'hEC, 8'h20);
    wr(8'hF8, 8'h00);
    @(posedge clk) sag_seen <= 1'b1;
    obs(6);
    @(posedge clk) sag_seen <= 1'b0;
    obs(6);
    rd(8'hF8, 8'h60);
    chk(psm_irq_r, 1'b1);
    wr(8'hEC, 8'h00);
    obs(3);
    chk(psm_irq_r, 1'b0);
    summarize();
  end
endmodule
